/* File: verilog/tpo_regs.svh */
// Constants for the table pulse output channel.
`ifndef TPO_REGS_SVH
`define TPO_REGS_SVH
`define TPO_CLK_HZ        32'd20000000
`define TPO_FREQ_MIN_HZ   32'd6
`define TPO_FREQ_MAX_HZ   32'd100000
`define TPO_SEG_MIN       6'd1
`define TPO_SEG_MAX       6'd40
`define TPO_WORDS_PER_SEG 8'd4
`define TPO_FREQ_W0       2'd0
`define TPO_CNT_W0        2'd2
`define TPO_MODE_TABLE    1'b0
`define TPO_MODE_ABS      1'b1
`endif

/* File: verilog/tpo_pkg.sv */
// Types shared by the table pulse output channel.
package tpo_pkg;
    typedef enum logic [1:0] {
        TPO_IDLE,
        TPO_LOAD,
        TPO_RUN,
        TPO_FETCH
    } tpo_state_e;

    typedef struct packed {
        logic [31:0] freq_hz;
        logic [31:0] pulses;
    } tpo_seg_s;

    typedef struct packed {
        logic pulse;
        logic dir;
    } tpo_pin_s;
endpackage

/* File: verilog/tpo_rate_gen.sv */
// Pulse rate generator: emits a square wave at a clamped frequency.
`timescale 1ns/1ns
`include "tpo_regs.svh"
module tpo_rate_gen (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        ce_in,
    // Control
    input  wire logic        run_in,
    input  wire logic [31:0] freq_in,
    // Result
    output logic             pulse_out,
    output logic             edge_out
);
    logic [31:0] freq_clamped;
    logic [31:0] accum_reg;
    logic [32:0] sum;

    always_comb begin
        if (freq_in < `TPO_FREQ_MIN_HZ) begin
            freq_clamped = `TPO_FREQ_MIN_HZ;
        end else if (freq_in > `TPO_FREQ_MAX_HZ) begin
            freq_clamped = `TPO_FREQ_MAX_HZ;
        end else begin
            freq_clamped = freq_in;
        end
    end

    // Phase accumulator toggles at twice the output rate.
    assign sum = {1'b0, accum_reg} + {1'b0, freq_clamped} + {1'b0, freq_clamped};

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            accum_reg <= 32'h0;
            pulse_out <= 1'b0;
            edge_out  <= 1'b0;
        end else if (ce_in) begin
            edge_out <= 1'b0;
            if (!run_in) begin
                accum_reg <= 32'h0;
                pulse_out <= 1'b0;
            end else if (sum[31:0] >= `TPO_CLK_HZ) begin
                accum_reg <= sum[31:0] - `TPO_CLK_HZ;
                pulse_out <= ~pulse_out;
                // A pulse is counted on its rising edge.
                edge_out  <= ~pulse_out;
            end else begin
                accum_reg <= sum[31:0];
            end
        end
    end
endmodule

/* File: verilog/tpo_channel.sv */
// Table-driven and absolute-target pulse/direction output channel.
//
// What this block does
// - Segment frequencies are kept within six hertz to one hundred kHz.
// - The segment now playing is reported and refreshed each scan.
// - Table mode drives only the pulse pin, never the direction pin.
// - Dropping the enable in table mode stops pulses at once.
// - Parameters changed during a run are ignored until it ends.
// - With the cyclic flag set the table restarts after its last segment.
// - A target above the present count moves forward, direction low.
// - A target below the present count moves backward, direction high.
// - Output uses pulse plus direction signalling only.
// - A done flag rises when the commanded pulses have all gone out, unless the target equals the present count.
// - The present count is 32 bits split in high and low words.
// - The present count steps up forward and down backward per pulse.
`timescale 1ns/1ns
`include "tpo_regs.svh"
module tpo_channel #(
    parameter int MAX_SEGS = 40
) (
    // Clock, reset and enable
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 ce_in,
    // Command, sampled on scan; enable_in is also read every cycle of a run
    input  wire logic                 scan_in,
    input  wire logic                 enable_in,
    input  wire logic                 mode_abs_in,
    input  wire logic                 table_cyclic_flag_in,
    input  wire logic [5:0]           seg_total_in,
    input  wire logic signed [31:0]   abs_target_in,
    input  wire logic [31:0]          abs_freq_in,
    // Table read port, same clock
    output logic [7:0]                table_addr_out,
    input  wire logic [15:0]          table_data_in,
    // Status
    output logic [15:0]               seg_index_out,
    output logic                      ch0_done_flag_out,
    output logic [15:0]               ch0_pv_low_out,
    output logic [15:0]               ch0_pv_high_out,
    output logic                      busy_out,
    // Drive pins
    output tpo_pkg::tpo_pin_s         pin_out
);
    import tpo_pkg::*;

    tpo_state_e        state_reg;
    tpo_seg_s          seg_reg;
    logic [2:0]        word_reg;
    logic [5:0]        seg_reg_idx;
    logic [5:0]        seg_total_reg;
    logic              cyclic_reg;
    logic              mode_reg;
    logic              dir_reg;
    logic [31:0]       left_reg;
    logic signed [31:0] pv_reg;
    logic              gen_run;
    logic              gen_pulse;
    logic              gen_edge;
    logic              last_pulse;

    ////////////////////////////////////////////////////////////////////
    assign gen_run    = (state_reg == TPO_RUN) && enable_in;
    assign last_pulse = gen_edge && (left_reg == 32'd1);

    tpo_rate_gen u_rate (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .ce_in      (ce_in),
        .run_in     (gen_run),
        .freq_in    (seg_reg.freq_hz),
        .pulse_out  (gen_pulse),
        .edge_out   (gen_edge)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer: one scan starts a run; the run owns the channel.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg     <= TPO_IDLE;
            word_reg      <= 3'd0;
            seg_reg_idx   <= 6'd0;
            seg_total_reg <= 6'd1;
            cyclic_reg    <= 1'b0;
            mode_reg      <= `TPO_MODE_TABLE;
            dir_reg       <= 1'b0;
            seg_reg       <= '0;
            left_reg      <= 32'h0;
        end else if (ce_in) begin
            case (state_reg)
                TPO_IDLE: begin
                    if (scan_in && enable_in) begin
                        mode_reg      <= mode_abs_in;
                        cyclic_reg    <= table_cyclic_flag_in;
                        seg_reg_idx   <= 6'd0;
                        word_reg      <= 3'd0;
                        if (seg_total_in < `TPO_SEG_MIN) begin
                            seg_total_reg <= `TPO_SEG_MIN;
                        end else if (seg_total_in > 6'(MAX_SEGS)) begin
                            seg_total_reg <= 6'(MAX_SEGS);
                        end else begin
                            seg_total_reg <= seg_total_in;
                        end
                        if (mode_abs_in == `TPO_MODE_ABS) begin
                            seg_reg.freq_hz <= abs_freq_in;
                            if (abs_target_in > pv_reg) begin
                                dir_reg  <= 1'b0;
                                left_reg <= 32'(abs_target_in - pv_reg);
                                state_reg <= TPO_RUN;
                            end else if (abs_target_in < pv_reg) begin
                                dir_reg  <= 1'b1;
                                left_reg <= 32'(pv_reg - abs_target_in);
                                state_reg <= TPO_RUN;
                            end
                        end else begin
                            dir_reg   <= 1'b0;
                            state_reg <= TPO_LOAD;
                        end
                    end
                end
                TPO_LOAD, TPO_FETCH: begin
                    case (word_reg)
                        3'd2: seg_reg.freq_hz[15:0]  <= table_data_in;
                        3'd3: seg_reg.freq_hz[31:16] <= table_data_in;
                        3'd4: seg_reg.pulses[15:0]   <= table_data_in;
                        3'd5: seg_reg.pulses[31:16]  <= table_data_in;
                        default: ;
                    endcase
                    word_reg <= word_reg + 3'd1;
                    if (word_reg == 3'd5) begin
                        left_reg  <= {table_data_in, seg_reg.pulses[15:0]};
                        state_reg <= TPO_RUN;
                    end
                    if (!enable_in) begin
                        state_reg <= TPO_IDLE;
                    end
                end
                TPO_RUN: begin
                    if (!enable_in) begin
                        state_reg <= TPO_IDLE;
                    end else if (left_reg == 32'h0 || last_pulse) begin
                        left_reg <= 32'h0;
                        if (mode_reg == `TPO_MODE_ABS) begin
                            state_reg <= TPO_IDLE;
                        end else if (seg_reg_idx + 6'd1 < seg_total_reg) begin
                            seg_reg_idx <= seg_reg_idx + 6'd1;
                            word_reg    <= 3'd0;
                            state_reg   <= TPO_FETCH;
                        end else if (cyclic_reg) begin
                            seg_reg_idx <= 6'd0;
                            word_reg    <= 3'd0;
                            state_reg   <= TPO_FETCH;
                        end else begin
                            state_reg <= TPO_IDLE;
                        end
                    end else if (gen_edge) begin
                        left_reg <= left_reg - 32'd1;
                    end
                end
                default: state_reg <= TPO_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Table address: the address register and the synchronous table read
    // each cost a cycle, so a word is captured two steps after it is asked.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            table_addr_out <= 8'h00;
        end else if (ce_in) begin
            table_addr_out <= 8'(seg_reg_idx * `TPO_WORDS_PER_SEG)
                              + 8'(word_reg[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // present count steps.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pv_reg <= 32'sh0;
        end else if (ce_in && gen_edge && state_reg == TPO_RUN
                     && left_reg != 32'h0) begin
            pv_reg <= dir_reg ? pv_reg - 32'sd1 : pv_reg + 32'sd1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status and pins.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            seg_index_out     <= 16'h0000;
            ch0_done_flag_out <= 1'b0;
            ch0_pv_low_out    <= 16'h0000;
            ch0_pv_high_out   <= 16'h0000;
            busy_out          <= 1'b0;
            pin_out           <= '0;
        end else if (ce_in) begin
            if (scan_in) begin
                seg_index_out <= 16'(seg_reg_idx) + 16'h0001;
            end
            if (scan_in && enable_in && state_reg == TPO_IDLE) begin
                ch0_done_flag_out <= 1'b0;
            end else if (state_reg == TPO_RUN && enable_in
                         && (left_reg == 32'h0 || last_pulse)
                         && (mode_reg == `TPO_MODE_ABS
                             || (seg_reg_idx + 6'd1 >= seg_total_reg
                                 && !cyclic_reg))) begin
                ch0_done_flag_out <= 1'b1;
            end
            ch0_pv_low_out  <= pv_reg[15:0];
            ch0_pv_high_out <= pv_reg[31:16];
            busy_out        <= (state_reg != TPO_IDLE);
            pin_out.pulse <= gen_pulse && gen_run;
            pin_out.dir   <= (mode_reg == `TPO_MODE_ABS) ? dir_reg
                                                          : 1'b0;
        end
    end
endmodule

/* File: dv/tpo_channel_sva.sv */
// Assertions on the ports of the table pulse output channel.
`timescale 1ns/1ns
module tpo_channel_sva (
    // Clock and reset
    input wire logic               clk_in,
    input wire logic               reset_n_in,
    // Command
    input wire logic               ce_in,
    input wire logic               scan_in,
    input wire logic               enable_in,
    input wire logic               mode_abs_in,
    input wire logic signed [31:0] abs_target_in,
    // Status and pins
    input wire logic [15:0]        seg_index_out,
    input wire logic               ch0_done_flag_out,
    input wire logic [15:0]        ch0_pv_low_out,
    input wire logic [15:0]        ch0_pv_high_out,
    input wire logic               busy_out,
    input wire tpo_pkg::tpo_pin_s  pin_out
);
    import tpo_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic signed [31:0] pv;
    logic               start;
    logic               mode_q;
    logic               fwd_q;
    logic [7:0]         lo_q;
    assign pv = {ch0_pv_high_out, ch0_pv_low_out};
    assign start = scan_in && enable_in && ce_in && !busy_out;
    // Mode and direction are judged against what was latched at start.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_q <= 1'b0;
            fwd_q  <= 1'b0;
        end else if (start) begin
            mode_q <= mode_abs_in;
            fwd_q  <= abs_target_in > pv;
        end
    end
    // Low time bounds the rate even where a segment end cuts a pulse short.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lo_q <= 8'h00;
        end else if (pin_out.pulse) begin
            lo_q <= 8'h00;
        end else if (lo_q != 8'hFF) begin
            lo_q <= lo_q + 8'h01;
        end
    end
    tab_nodir_a: assert property (
        busy_out && $past(busy_out) && !mode_q |-> !pin_out.dir)
        else $error("direction driven in table mode");
    halt_now_a: assert property (
        $fell(enable_in) && !mode_q |=> ##1 (!$rose(pin_out.pulse))[*8])
        else $error("pulses continue after enable drop");
    fwd_dir_a: assert property (
        busy_out && $past(busy_out) && mode_q && fwd_q |-> !pin_out.dir)
        else $error("forward move with direction high");
    bwd_dir_a: assert property (
        busy_out && $past(busy_out) && mode_q && !fwd_q |-> pin_out.dir)
        else $error("backward move with direction low");
    pv_step_a: assert property (
        $changed(pv) |-> (pv == $past(pv) + 1 && !pin_out.dir)
        || (pv == $past(pv) - 1 && pin_out.dir))
        else $error("present count stepped wrongly");
    busy_start_a: assert property (
        start && !mode_abs_in |-> ##[1:2] busy_out)
        else $error("table run did not start");
    seg_scan_a: assert property (
        $changed(seg_index_out) |-> $past(scan_in))
        else $error("segment index changed off scan");
    clamp_hi_a: assert property (
        $rose(pin_out.pulse) |-> lo_q >= 8'd90)
        else $error("pulse faster than the band allows");
    done_hold_a: assert property (
        ch0_done_flag_out && !scan_in && !$past(scan_in)
        |=> ch0_done_flag_out)
        else $error("done flag dropped without a start");
    cover property ($rose(ch0_done_flag_out) && mode_q);
    cover property (busy_out && mode_q && !fwd_q);
    cover property (busy_out && !mode_q && seg_index_out == 16'h0002);
endmodule
bind tpo_channel tpo_channel_sva tpo_channel_sva_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .scan_in(scan_in), .enable_in(enable_in), .mode_abs_in(mode_abs_in),
    .abs_target_in(abs_target_in), .seg_index_out(seg_index_out),
    .ch0_done_flag_out(ch0_done_flag_out), .busy_out(busy_out),
    .ch0_pv_low_out(ch0_pv_low_out), .ch0_pv_high_out(ch0_pv_high_out),
    .pin_out(pin_out));

/* File: dv/tpo_drive_model.sv */
// Behavioural pulse/direction drive that tracks its own position.
`timescale 1ns/1ns
module tpo_drive_model (
    // Pins from the channel
    input  wire logic              reset_n_in,
    input  wire tpo_pkg::tpo_pin_s pin_in,
    // Position seen by the drive
    output logic signed [31:0]     pos_out,
    output logic [31:0]            edges_out
);
    import tpo_pkg::*;
    always @(posedge pin_in.pulse or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pos_out   <= 32'h00000000;
            edges_out <= 32'h00000000;
        end else begin
            edges_out <= edges_out + 32'h00000001;
            pos_out   <= pin_in.dir ? pos_out - 1 : pos_out + 1;
        end
    end
endmodule

/* File: dv/tpo_channel_tb.sv */
// Self-checking bench for the table pulse output channel.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t: value mismatch", $time); end end
module tpo_channel_tb;
    import tpo_pkg::*;
    logic clk_in = 0, reset_n_in = 0, scan_in = 0, enable_in = 0;
    logic mode_abs_in = 0, table_cyclic_flag_in = 0, done_q = 0;
    logic ce_in = 1;
    logic [5:0] seg_total_in = 6'h01;
    logic signed [31:0] abs_target_in = 0, drv_pos;
    logic [31:0] abs_freq_in = 32'h000186A0, drv_edges, e0, n1, e1, pv_frz;
    logic [7:0] table_addr_out;
    logic [15:0] table_data_in = 0, seg_index_out, pv_lo, pv_hi;
    logic ch0_done_flag_out, busy_out;
    tpo_pin_s pin_out;
    logic [15:0] mem [256];
    logic [31:0] expq [$];
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    always #25 clk_in = ~clk_in;
    always @(negedge clk_in) begin
        cyc++;
        scan_in <= (cyc % 8 == 0);
    end
    always @(posedge clk_in) table_data_in <= mem[table_addr_out];
    tpo_channel tpo_channel_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .ce_in(ce_in), .scan_in(scan_in), .enable_in(enable_in),
        .mode_abs_in(mode_abs_in), .table_cyclic_flag_in(table_cyclic_flag_in),
        .seg_total_in(seg_total_in), .abs_target_in(abs_target_in),
        .abs_freq_in(abs_freq_in), .table_addr_out(table_addr_out),
        .table_data_in(table_data_in), .seg_index_out(seg_index_out),
        .ch0_done_flag_out(ch0_done_flag_out), .ch0_pv_low_out(pv_lo),
        .ch0_pv_high_out(pv_hi), .busy_out(busy_out), .pin_out(pin_out));
    tpo_drive_model tpo_drive_model_i (.reset_n_in(reset_n_in),
        .pin_in(pin_out), .pos_out(drv_pos), .edges_out(drv_edges));
    // The count lags the last pulse, so compare a little after done rises.
    always @(negedge clk_in) begin
        done_q <= ch0_done_flag_out;
        if (ch0_done_flag_out === 1'b1 && done_q !== 1'b1 &&
            expq.size() > 0) begin
            repeat (2) @(negedge clk_in);
            `CHK({pv_hi, pv_lo}, expq.pop_front())
            `CHK(drv_pos, {pv_hi, pv_lo})
        end
    end
    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_for(input bit on_done, input logic v);
        for (int i = 0; i < 20000; i++) begin
            if ((on_done ? ch0_done_flag_out : busy_out) === v) return;
            @(negedge clk_in);
        end
        n_mismatch++;
        give_verdict();
    endtask
    task automatic set_seg(input int s, input logic [31:0] f, p);
        mem[s*4] = f[15:0];
        mem[s*4+1] = f[31:16];
        mem[s*4+2] = p[15:0];
        mem[s*4+3] = p[31:16];
    endtask
    task automatic start(input logic m, c, input logic [31:0] t,
                         input logic [5:0] n);
        @(negedge clk_in);
        mode_abs_in = m;
        table_cyclic_flag_in = c;
        abs_target_in = t;
        seg_total_in = n;
        enable_in = 1'b1;
        wait_for(1'b0, 1'b1);
    endtask
    task automatic run(input logic m, input logic [31:0] t, e,
                       input logic [5:0] n);
        expq.push_back(e);
        start(m, 1'b0, t, n);
        seg_total_in = 6'h05;
        abs_target_in = $urandom;
        wait_for(1'b1, 1'b1);
        enable_in = 1'b0;
        repeat (12) @(negedge clk_in);
    endtask
    initial begin
        void'($urandom(1));
        n1 = $urandom_range(4, 1);
        set_seg(0, 32'h000186A0, n1);
        set_seg(1, 32'h00030D40, 32'h00000002);
        repeat (3) @(negedge clk_in);
        reset_n_in = 1'b1;
        run(1'b1, -3, -3, 6'h01);
        run(1'b0, 0, n1 - 1, 6'h02);
        run(1'b1, 4, 4, 6'h01);
        @(negedge clk_in);
        abs_target_in = 4;
        enable_in = 1'b1;
        repeat (20) @(negedge clk_in);
        `CHK(busy_out, 1'b0)
        `CHK({pv_hi, pv_lo}, 32'd4)
        enable_in = 1'b0;
        set_seg(0, 32'h000186A0, 32'h00000002);
        e0 = drv_edges;
        start(1'b0, 1'b1, 0, 6'h01);
        repeat (1500) @(negedge clk_in);
        `CHK(seg_index_out, 16'h0001)
        // A low clock enable must freeze the count and the pins.
        ce_in = 1'b0;
        pv_frz = {pv_hi, pv_lo};
        e1 = drv_edges;
        repeat (300) @(negedge clk_in);
        `CHK({pv_hi, pv_lo}, pv_frz)
        `CHK(drv_edges, e1)
        ce_in = 1'b1;
        enable_in = 1'b0;
        wait_for(1'b0, 1'b0);
        repeat (4) @(negedge clk_in);
        `CHK(drv_edges - e0 > 32'd3, 1'b1)
        `CHK({pv_hi, pv_lo}, drv_pos)
        `CHK(expq.size(), 0)
        give_verdict();
    end
endmodule
